// >>> src/bbw_pkg.sv
// Constants, register map and field layout of the bus watchpoint.
// Assumes one 50 MHz clock and a 32-bit AXI4-Lite register port.
package bbw_pkg;
  // ==========================================================
  // Register map
  localparam logic [4:0] ADR_BRK_ADDR = 5'h00;
  localparam logic [4:0] ADR_BRK_MASK = 5'h04;
  localparam logic [4:0] ADR_CYC_SEL = 5'h08;
  localparam logic [4:0] ADR_BRK_CTRL = 5'h0c;
  localparam logic [4:0] ADR_STATUS = 5'h10;
  localparam logic [4:0] ADR_WORD_MASK = 5'h1c;
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [7:0] RST_CYC = 8'h00;
  localparam logic [2:0] RST_CTRL = 3'h0;
  // ==========================================================
  // Field layout
  localparam int CYC_W = 8;
  localparam int CTRL_W = 3;
  localparam int OWN_LSB = 6;
  localparam int FD_LSB = 4;
  localparam int DIR_LSB = 2;
  localparam int SZ_LSB = 0;
  localparam int WSEL_LSB = 1;
  localparam int DIS_BIT = 0;
  localparam int ST_PEND = 0;
  localparam int ST_TRIG = 1;
  localparam int ST_SLOT = 2;
  localparam int ST_DATA = 3;
  // ==========================================================
  // Encodings
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SZ_ANY = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LONG = 2'h3;
  localparam logic [3:0] BRK_LEVEL = 4'hf;
  localparam logic [3:0] MASK_MAX_OK = 4'he;
  localparam logic [31:0] INSN_STEP = 32'h0000_0002;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Trigger widths in clock periods per width code
  localparam logic [4:0] TW_1 = 5'h01;
  localparam logic [4:0] TW_4 = 5'h04;
  localparam logic [4:0] TW_8 = 5'h08;
  localparam logic [4:0] TW_16 = 5'h10;
  typedef logic [4:0] bbw_cnt_t;
endpackage

// >>> src/bbw_cmp_if.sv
// Carries settings and one observed bus cycle to the comparator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface bbw_cmp_if;
  logic [31:0] brk_addr;
  logic [31:0] brk_mask;
  logic [7:0] cyc_sel;
  logic cyc_valid;
  logic [31:0] cyc_addr;
  logic cyc_dtc;
  logic cyc_fetch;
  logic cyc_write;
  logic [1:0] cyc_size;
  logic cyc_dual;
  logic [1:0] hit;
  modport owner (output brk_addr, brk_mask, cyc_sel, cyc_valid,
    cyc_addr, cyc_dtc, cyc_fetch, cyc_write, cyc_size, cyc_dual,
    input hit);
  modport matcher (input brk_addr, brk_mask, cyc_sel, cyc_valid,
    cyc_addr, cyc_dtc, cyc_fetch, cyc_write, cyc_size, cyc_dual,
    output hit);
endinterface

// >>> src/bbw_match.sv
// Combinational break-condition comparator, one lane per instruction.
// Assumes the bus cycle is stable in the cycle its valid is high.
`timescale 1ns/10ps
module bbw_match
  import bbw_pkg::*;
(
  bbw_cmp_if.matcher cmp
);
  // ==========================================================
  // Cycle class decode
  wire [1:0] own_sel = cmp.cyc_sel[OWN_LSB+:2];
  wire [1:0] fd_sel = cmp.cyc_sel[FD_LSB+:2];
  wire [1:0] dir_sel = cmp.cyc_sel[DIR_LSB+:2];
  wire [1:0] sz_sel = cmp.cyc_sel[SZ_LSB+:2];
  // Code 00 enables no bit, so an owner, fetch or direction group at 00 can never pass
  wire own_ok = own_sel[0] & ~cmp.cyc_dtc |
    own_sel[1] & cmp.cyc_dtc;
  wire fd_ok = fd_sel[0] & cmp.cyc_fetch |
    fd_sel[1] & ~cmp.cyc_fetch;
  // Fetches are reads
  wire is_wr = cmp.cyc_write & ~cmp.cyc_fetch;
  wire dir_ok = dir_sel[0] & ~is_wr | dir_sel[1] & is_wr;
  wire [1:0] eff_size = cmp.cyc_fetch ? SZ_WORD : cmp.cyc_size;
  wire sz_ok = sz_sel == SZ_ANY || sz_sel == eff_size;
  wire cls_ok = cmp.cyc_valid & own_ok & fd_ok & dir_ok & sz_ok;
  // ==========================================================
  // Address lanes: lane 1 is the second instruction of a dual fetch
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      wire [31:0] lane_addr = cmp.cyc_addr + (g == 0 ? 32'h0 : INSN_STEP);
      wire lane_use = g == 0 || cmp.cyc_fetch && cmp.cyc_dual;
      // Exact compare of unmasked bits; an odd address meets an even one only if mask bit 0 is set
      // Set mask bits drop address bits
      assign cmp.hit[g] = cls_ok & lane_use &
        ~|((lane_addr ^ cmp.brk_addr) & ~cmp.brk_mask);
    end
  endgenerate
endmodule

// >>> src/bbw_top.sv
// Bus-cycle watchpoint: AXI4-Lite registers, match, trigger, request.
// Assumes bus cycle inputs and irq controller signals share aclk.
`timescale 1ns/10ps
module bbw_top
  import bbw_pkg::*;
#(
  parameter int ADDR_W = 32
)(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Observed bus cycle
  input wire logic cyc_valid,
  input wire logic [31:0] cyc_addr,
  input wire logic cyc_dtc,
  input wire logic cyc_fetch,
  input wire logic cyc_write,
  input wire logic [1:0] cyc_size,
  input wire logic cyc_dual,
  // Interrupt controller side
  input wire logic [3:0] cpu_irq_mask_level,
  input wire logic break_irq_ack,
  output logic break_irq_req,
  output logic [3:0] break_irq_level,
  output logic [31:0] break_pc,
  output logic break_after_first,
  output logic break_is_data,
  // External monitor
  output logic match_trigger_n
);
  // ==========================================================
  // Elaboration check
  generate
    if (ADDR_W != 32) begin : g_chk
      $error("bbw_top serves a 32-bit address only");
    end
  endgenerate

  // ==========================================================
  // Registers
  logic [31:0] break_address_r;
  logic [31:0] break_address_mask_r;
  logic [CYC_W-1:0] bus_cycle_select_r;
  logic [CTRL_W-1:0] break_control_r;
  logic pend_r;
  logic [31:0] pc_r;
  logic slot_r;
  logic data_r;
  bbw_cnt_t trig_cnt_r;
  logic [4:0] aw_addr_r;
  logic aw_full_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_full_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ==========================================================
  // Comparator
  bbw_cmp_if cmp ();
  assign cmp.brk_addr = break_address_r;
  assign cmp.brk_mask = break_address_mask_r;
  assign cmp.cyc_sel = bus_cycle_select_r;
  assign cmp.cyc_valid = cyc_valid;
  assign cmp.cyc_addr = cyc_addr;
  assign cmp.cyc_dtc = cyc_dtc;
  assign cmp.cyc_fetch = cyc_fetch;
  assign cmp.cyc_write = cyc_write;
  assign cmp.cyc_size = cyc_size;
  assign cmp.cyc_dual = cyc_dual;

  bbw_match u_match (
    .cmp(cmp)
  );

  wire match = |cmp.hit;
  wire irq_dis = break_control_r[DIS_BIT];
  wire [1:0] wsel = break_control_r[WSEL_LSB+:2];

  // ==========================================================
  // Write channel
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_full_r & w_full_r & ~bvalid_r;
  wire [31:0] strb_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
    {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire wr_addr_hit = wr_go & aw_addr_r == ADR_BRK_ADDR;
  wire wr_mask_hit = wr_go & aw_addr_r == ADR_BRK_MASK;
  wire wr_cyc_hit = wr_go & aw_addr_r == ADR_CYC_SEL;
  wire wr_ctrl_hit = wr_go & aw_addr_r == ADR_BRK_CTRL;
  wire wr_mapped = wr_addr_hit | wr_mask_hit | wr_cyc_hit |
    wr_ctrl_hit | aw_addr_r == ADR_STATUS;
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] dat, input logic [31:0] m);
    merge = old & ~m | dat & m;
  endfunction
  wire [31:0] addr_nxt = merge(break_address_r, w_data_r, strb_mask);
  wire [31:0] mask_nxt = merge(break_address_mask_r, w_data_r,
    strb_mask);
  wire [31:0] cyc_full = merge({24'h0, bus_cycle_select_r}, w_data_r,
    strb_mask);
  // Reserved control bits are not stored
  wire [31:0] ctrl_full = merge({29'h0, break_control_r}, w_data_r,
    strb_mask);

  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready = ~w_full_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 5'h00;
    end else if (aw_take) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr & ADR_WORD_MASK;
    end else if (wr_go) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else if (w_take) begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Mask bits reset to 0, so every address bit compares
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_address_r <= RST_ADDR;
      break_address_mask_r <= RST_MASK;
      bus_cycle_select_r <= RST_CYC;
      break_control_r <= RST_CTRL;
    end else begin
      if (wr_addr_hit)
        break_address_r <= addr_nxt;
      if (wr_mask_hit)
        break_address_mask_r <= mask_nxt;
      if (wr_cyc_hit)
        bus_cycle_select_r <= cyc_full[CYC_W-1:0];
      if (wr_ctrl_hit)
        break_control_r <= ctrl_full[CTRL_W-1:0];
    end
  end

  // ==========================================================
  // Read channel
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [4:0] ar_a = s_axi_araddr & ADR_WORD_MASK;
  wire [31:0] status_w = {28'h0, data_r, slot_r, ~match_trigger_n,
    pend_r};
  wire rd_map = ar_a == ADR_BRK_ADDR | ar_a == ADR_BRK_MASK |
    ar_a == ADR_CYC_SEL | ar_a == ADR_BRK_CTRL | ar_a == ADR_STATUS;
  wire [31:0] rd_mux =
    ar_a == ADR_BRK_ADDR ? break_address_r :
    ar_a == ADR_BRK_MASK ? break_address_mask_r :
    ar_a == ADR_CYC_SEL ? {24'h0, bus_cycle_select_r} :
    ar_a == ADR_BRK_CTRL ? {29'h0, break_control_r} :
    ar_a == ADR_STATUS ? status_w : 32'h0;

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_map ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Break request and captured break point
  wire raise = match & ~irq_dis;
  wire pend_nxt = raise | pend_r & ~break_irq_ack;
  wire lane1_only = cmp.hit[1] & ~cmp.hit[0];
  // Held until the controller accepts; blocked at mask level 15
  assign break_irq_req = pend_r &
    cpu_irq_mask_level <= MASK_MAX_OK;
  assign break_irq_level = BRK_LEVEL;
  assign break_pc = pc_r;
  assign break_after_first = slot_r;
  assign break_is_data = data_r;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      pend_r <= 1'b0;
    else
      pend_r <= pend_nxt; // Set wins over the acknowledge
  end

  // The processor moves the point past delay slots and uses its own PC
  // for data breaks; this block reports the matched address and kind
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_r <= 32'h0;
      slot_r <= 1'b0;
      data_r <= 1'b0;
    end else if (raise) begin
      pc_r <= lane1_only ? cyc_addr + INSN_STEP
        : cyc_addr;
      slot_r <= lane1_only;
      data_r <= ~cyc_fetch;
    end
  end

  // ==========================================================
  // Trigger pulse
  wire bbw_cnt_t tw_load = wsel == 2'h0 ? TW_1 :
    wsel == 2'h1 ? TW_4 : wsel == 2'h2 ? TW_8 : TW_16;

  // Every match reloads the full width
  always_ff @(posedge aclk) begin
    if (!aresetn)
      trig_cnt_r <= '0;
    else if (match)
      trig_cnt_r <= tw_load;
    else if (trig_cnt_r != '0)
      trig_cnt_r <= trig_cnt_r - 5'h01;
  end

  assign match_trigger_n = trig_cnt_r == '0;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_trig_four: assert property (match && wsel == 2'h1 |=>
    !match_trigger_n [*4])
    else $error("trigger shorter than four clocks");
  a_trig_eight: assert property (match && wsel == 2'h2 |=>
    !match_trigger_n [*8])
    else $error("trigger shorter than eight clocks");
  a_trig_sixteen: assert property (match && wsel == 2'h3 |=>
    !match_trigger_n [*8] ##1 !match_trigger_n [*8])
    else $error("trigger shorter than sixteen clocks");
  a_trig_end: assert property (match && wsel == 2'h1
    ##1 !match [*4] |=> match_trigger_n)
    else $error("trigger not released after four clocks");
  a_trig_one: assert property (match && wsel == 2'h0
    ##1 !match |-> !match_trigger_n ##1 match_trigger_n)
    else $error("one-clock trigger width wrong");
  a_irq_disable: assert property (!pend_r && match && irq_dis
    && !break_irq_ack |=> !pend_r)
    else $error("request raised while disabled");
  a_disable_trig: assert property (match && irq_dis |=>
    !match_trigger_n)
    else $error("no trigger while requests are disabled");
  a_irq_raise: assert property (match && !irq_dis |=>
    pend_r && !match_trigger_n)
    else $error("match did not raise request and trigger");
  a_mask_hold: assert property (pend_r && !break_irq_ack
    && cpu_irq_mask_level == 4'hf |-> !break_irq_req ##1 pend_r)
    else $error("request not held pending at level 15");
  a_mask_block: assert property (
    cpu_irq_mask_level > MASK_MAX_OK |-> !break_irq_req)
    else $error("request offered at mask level 15");
  a_mask_accept: assert property (pend_r
    && cpu_irq_mask_level < 4'hf |-> break_irq_req)
    else $error("request not offered at low mask level");
  a_ack_clear: assert property (pend_r && break_irq_ack
    && !raise |=> !pend_r)
    else $error("acknowledged request still pending");
  a_sel_none: assert property (
    bus_cycle_select_r[OWN_LSB+:2] == SEL_NONE ||
    bus_cycle_select_r[FD_LSB+:2] == SEL_NONE ||
    bus_cycle_select_r[DIR_LSB+:2] == SEL_NONE |-> !match)
    else $error("match with a group at 00");
  a_fetch_write: assert property (cyc_fetch &&
    bus_cycle_select_r[FD_LSB+:2] == 2'h1 &&
    bus_cycle_select_r[DIR_LSB+:2] == 2'h2 |-> !match)
    else $error("fetch matched as a write");
  a_word_odd: assert property (!cyc_fetch
    && cyc_size == SZ_WORD && break_address_r[0]
    && !break_address_mask_r[0] && cyc_addr[0] == 1'b0 |-> !match)
    else $error("word access matched an odd address");
  a_slot_pc: assert property (raise && lane1_only |=>
    break_after_first && break_pc == $past(cyc_addr) + INSN_STEP)
    else $error("second-instruction break point wrong");
  a_fetch_pc: assert property (raise && !lane1_only |=>
    break_pc == $past(cyc_addr))
    else $error("first-instruction break point wrong");
  a_data_kind: assert property (raise |=>
    break_is_data == !$past(cyc_fetch))
    else $error("break kind not captured");
  a_ctrl_resv: assert property (ar_take
    && ar_a == ADR_BRK_CTRL |=> s_axi_rdata[31:3] == 29'h0)
    else $error("reserved control bits read nonzero");

  // Main scenarios the bench is expected to reach
  c_dual_hit: cover property (raise && lane1_only);
  c_silent_trig: cover property (match && irq_dis);
  c_retrigger: cover property (!match_trigger_n && match);
  c_pend_held: cover property (pend_r && cpu_irq_mask_level == 4'hf
    ##1 break_irq_req);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// >>> dv/bbw_partner.sv
// Far-side model: interrupt controller acknowledge and trigger monitor.
// Assumes it shares aclk and aresetn with the watchpoint.
`timescale 1ns/10ps
module bbw_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic break_irq_req,
  input wire logic match_trigger_n,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  output logic break_irq_ack,
  output logic [7:0] trig_width
);
  logic [3:0] wait_r;
  logic [7:0] low_r;
  // ==========================================================
  // Accepts a request only once it has stood ack_delay+1 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_r <= 4'h0;
      break_irq_ack <= 1'b0;
    end else begin
      break_irq_ack <= 1'b0;
      // Only an offered request is acknowledged
      if (!break_irq_req || break_irq_ack || !ack_en) begin
        wait_r <= 4'h0;
      end else if (wait_r == ack_delay) begin
        break_irq_ack <= 1'b1;
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
  // ==========================================================
  // Counts the clocks of each low trigger pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_r <= 8'h00;
      trig_width <= 8'h00;
    end else if (!match_trigger_n) begin
      low_r <= low_r + 8'h01;
    end else if (low_r != 8'h00) begin
      trig_width <= low_r;
      low_r <= 8'h00;
    end
  end
endmodule

// >>> dv/testbench.sv
// Self-checking bench of the bus watchpoint over AXI4-Lite.
// Assumes the far-side model in bbw_partner and a 50 MHz clock.
`timescale 1ns/10ps
module testbench;
  import bbw_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, cyc_addr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0, cpu_irq_mask_level = 4'h0;
  logic cyc_valid = 1'b0, cyc_dtc = 1'b0, cyc_fetch = 1'b0;
  logic cyc_write = 1'b0, cyc_dual = 1'b0, ack_en = 1'b1;
  logic [1:0] cyc_size = 2'h0, s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, break_irq_ack, break_irq_req;
  logic break_after_first, break_is_data, match_trigger_n;
  logic [31:0] s_axi_rdata, break_pc, d;
  logic [3:0] break_irq_level;
  logic [7:0] trig_width;
  logic [7:0] wtab [4] = '{8'h01, 8'h04, 8'h08, 8'h10};
  logic [7:0] nsel [3] = '{8'h2a, 8'h4a, 8'h62};
  int n_errors = 0, checks = 0;
  always #10 aclk = ~aclk;
  bbw_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cyc_valid, .cyc_addr,
    .cyc_dtc, .cyc_fetch, .cyc_write, .cyc_size, .cyc_dual,
    .cpu_irq_mask_level, .break_irq_ack, .break_irq_req,
    .break_irq_level, .break_pc, .break_after_first, .break_is_data,
    .match_trigger_n);
  bbw_partner u_far (.aclk, .aresetn, .break_irq_req, .match_trigger_n,
    .ack_en, .ack_delay(4'h2), .break_irq_ack, .trig_width);
  // ==========================================================
  // Reporting
  task automatic report_and_stop();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // ==========================================================
  // AXI4-Lite master; ready is looked at before the edge it is taken
  task automatic axi_write(input logic [4:0] a, input logic [31:0] v,
    output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end while (!tb);
  endtask
  task automatic axi_read(input logic [4:0] a, output logic [31:0] v,
    output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end while (!tr);
  endtask
  task automatic cfg(input logic [31:0] ad, input logic [31:0] mk,
    input logic [7:0] sel, input logic [2:0] ct);
    axi_write(ADR_BRK_ADDR, ad, rsp);
    axi_write(ADR_BRK_MASK, mk, rsp);
    axi_write(ADR_CYC_SEL, {24'h0, sel}, rsp);
    axi_write(ADR_BRK_CTRL, {29'h0, ct}, rsp);
    chk_word("write resp", 32'h0, {30'h0, rsp});
  endtask
  // ==========================================================
  // One observed bus cycle; outputs are looked at after its edge
  task automatic bus_cyc(input int n, input logic [31:0] a,
    input logic [3:0] kind, input logic [1:0] sz);
    repeat (n) @(posedge aclk);
    @(posedge aclk);
    cyc_valid <= 1'b1;
    cyc_addr <= a;
    {cyc_dtc, cyc_fetch, cyc_write, cyc_dual} <= kind;
    cyc_size <= sz;
    @(posedge aclk);
    cyc_valid <= 1'b0;
    #1;
  endtask
  task automatic cyc_exp(input logic [31:0] a, input logic [3:0] kind,
    input logic [1:0] sz, input logic hit);
    bus_cyc(20, a, kind, sz);
    chk_bit("match", hit, ~match_trigger_n);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ADR_BRK_CTRL, d, rsp);
    chk_word("ctrl reset", 32'h0, d);
    axi_read(ADR_BRK_MASK, d, rsp);
    chk_word("mask reset", 32'h0, d);
    axi_write(ADR_BRK_CTRL, 32'hffff_fffe, rsp);
    axi_read(ADR_BRK_CTRL, d, rsp);
    chk_word("ctrl reserved", 32'h6, d);
    axi_read(5'h14, d, rsp);
    chk_word("unmapped resp", 32'h3, {30'h0, rsp});
    for (int c = 0; c < 4; c++) begin
      cfg(32'h0012_3456, 32'h0, 8'h6a, 3'(c << 1));
      cyc_exp(32'h0012_3456, 4'h2, SZ_WORD, 1'b1);
      chk_bit("request", 1'b1, break_irq_req);
      chk_bit("data kind", 1'b1, break_is_data);
      repeat (20) @(posedge aclk);
      chk_word("width", {24'h0, wtab[c]}, {24'h0, trig_width});
    end
    chk_word("level", 32'hf, {28'h0, break_irq_level});
    cfg(32'h0012_3456, 32'h0, 8'h6a, 3'h2);
    bus_cyc(20, 32'h0012_3456, 4'h2, SZ_WORD);
    bus_cyc(1, 32'h0012_3456, 4'h2, SZ_WORD);
    repeat (20) @(posedge aclk);
    chk_word("restart width", 32'h7, {24'h0, trig_width});
    ack_en <= 1'b0;
    cpu_irq_mask_level <= 4'hf;
    cyc_exp(32'h0012_3456, 4'h2, SZ_WORD, 1'b1);
    chk_bit("masked req", 1'b0, break_irq_req);
    axi_read(ADR_STATUS, d, rsp);
    chk_bit("pending", 1'b1, d[ST_PEND]);
    cpu_irq_mask_level <= 4'he;
    @(posedge aclk);
    #1;
    chk_bit("unmasked req", 1'b1, break_irq_req);
    ack_en <= 1'b1;
    repeat (8) @(posedge aclk);
    chk_bit("acked req", 1'b0, break_irq_req);
    cfg(32'h0012_3456, 32'h0, 8'h6a, 3'h1);
    cyc_exp(32'h0012_3456, 4'h2, SZ_WORD, 1'b1);
    chk_bit("disabled req", 1'b0, break_irq_req);
    for (int i = 0; i < 3; i++) begin
      cfg(32'h0012_3456, 32'h0, nsel[i], 3'h0);
      cyc_exp(32'h0012_3456, 4'h2, SZ_WORD, 1'b0);
    end
    cfg(32'h0012_3456, 32'h0, 8'haa, 3'h0);
    cyc_exp(32'h0012_3456, 4'h2, SZ_WORD, 1'b0);
    cyc_exp(32'h0012_3456, 4'ha, SZ_WORD, 1'b1);
    cfg(32'h0012_3456, 32'h0, 8'hea, 3'h0);
    cyc_exp(32'h0012_3456, 4'h2, SZ_WORD, 1'b1);
    cfg(32'h0000_0404, 32'h0, 8'h58, 3'h0);
    cyc_exp(32'h0000_0404, 4'h4, SZ_ANY, 1'b0);
    cfg(32'h0000_0404, 32'h0, 8'h56, 3'h0);
    cyc_exp(32'h0000_0404, 4'h4, SZ_BYTE, 1'b1);
    chk_word("fetch pc", 32'h0000_0404, break_pc);
    chk_bit("fetch kind", 1'b0, break_is_data);
    chk_bit("first lane", 1'b0, break_after_first);
    cfg(32'h0000_0406, 32'h0, 8'h54, 3'h0);
    cyc_exp(32'h0000_0404, 4'h5, SZ_ANY, 1'b1);
    chk_word("second pc", 32'h0000_0406, break_pc);
    chk_bit("after first", 1'b1, break_after_first);
    cfg(32'h0003_0147, 32'h0, 8'h54, 3'h0);
    cyc_exp(32'h0003_0146, 4'h4, SZ_ANY, 1'b0);
    cfg(32'h00a8_0391, 32'h0, 8'h66, 3'h0);
    cyc_exp(32'h00a8_0390, 4'h0, SZ_WORD, 1'b0);
    cfg(32'h0000_1000, 32'h0000_000f, 8'h6a, 3'h0);
    cyc_exp(32'h0000_100c, 4'h2, SZ_WORD, 1'b1);
    cyc_exp(32'h0000_1010, 4'h2, SZ_WORD, 1'b0);
    cfg(32'h0000_2000, 32'h0, 8'h65, 3'h0);
    cyc_exp(32'h0000_2000, 4'h0, SZ_WORD, 1'b0);
    cyc_exp(32'h0000_2000, 4'h0, SZ_BYTE, 1'b1);
    cfg(32'h0000_2000, 32'h0, 8'h64, 3'h0);
    cyc_exp(32'h0000_2000, 4'h0, SZ_LONG, 1'b1);
    report_and_stop();
  end
endmodule
